// ### verilog/udma_crc_cfg.svh
// timing counts and fixed values for the data-out termination and crc block
`ifndef UDMA_CRC_CFG_SVH
`define UDMA_CRC_CFG_SVH
`define CRC_SEED 16'h4aba
`define ERR_ICRC_BIT 7
`define ERR_ABRT_BIT 2
`define SENSE_ABORTED 4'hb
`define SENSE_HW_ERR 4'h4
`define ASC_COMM_CRC 8'h08
`define ASCQ_COMM_CRC 8'h03
`define T_LI_NS 150
`define T_LI_CYC (((`T_LI_NS) / 8) > 0 ? ((`T_LI_NS) / 8) : 1)
`define T_ZIORDY_NS 20
`define T_ZIORDY_CYC (((`T_ZIORDY_NS) / 8) > 0 ? ((`T_ZIORDY_NS) / 8) : 1)
`endif

// ### verilog/udma_crc_pkg.sv
// types for the data-out termination and crc block
package udma_crc_pkg;
    typedef enum logic [1:0] {
        CMD_DMA_RW,
        CMD_PKT_SENSE,
        CMD_PKT_OTHER
    } cmd_kind_e;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_BURST,
        ST_STOPPING,
        ST_WAIT_ACK_END,
        ST_RELEASE
    } term_state_e;
endpackage : udma_crc_pkg

// ### verilog/udma_out_term_crc.sv
// device side of ultra dma data-out burst with host termination and burst crc
// Behaviour
// - device drops dmarq after stop, keeps low
// - device negates ready, keeps negated till end
// - non-data strobe reassertion is ignored
// - device latches host crc at dmack release
// - device releases ready after dmack release
// - separate 16-bit crc for every burst
// - crc loaded with seed at burst start
// - each data strobe edge folds word in
// - mismatch saved sticky, first error reported
// - dma commands report icrc and abort bits
// - sense crc error gives aborted command key
// - other packet error gives hardware key, asc
// - extra words enter crc but are discarded
// - polynomial x16+x12+x5+1, bit zero first
// - word clock from strobe, bits line up
// - crc checked only in ultra dma mode
`timescale 1ns/1ps
`include "udma_crc_cfg.svh"

module udma_out_term_crc
    import udma_crc_pkg::*;
#(
    parameter int WORDS_W = 16
) (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic DMACK_N,
    input wire logic STOP,
    input wire logic HSTROBE,
    input wire logic [15:0] DATA_IN,
    input wire logic UDMA_MODE,
    input wire logic CMD_START,
    input wire cmd_kind_e CMD_KIND,
    input wire logic [WORDS_W-1:0] CMD_WORDS,
    input wire logic BURST_REQ,
    input wire logic CMD_END,
    output logic DMARQ,
    output logic DDMARDY_N_O,
    output logic DDMARDY_N_OE,
    output logic WORD_VALID,
    output logic [15:0] WORD_DATA,
    output logic CRC_ERR,
    output logic [7:0] ERROR_REG,
    output logic CHK,
    output logic [3:0] SENSE_KEY,
    output logic [7:0] ASC,
    output logic [7:0] ASCQ,
    output logic DONE
);

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [1:0] ack_s_q, stop_s_q, strb_s_q;
    logic [15:0] dat_s1_q, dat_s2_q;
    logic ack_n, stop_i, strb_i, strb_prev_q;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            ack_s_q <= 2'h3;
            stop_s_q <= 2'h0;
            strb_s_q <= 2'h3;
            dat_s1_q <= 16'h0000;
            dat_s2_q <= 16'h0000;
            strb_prev_q <= 1'b1;
        end else begin
            ack_s_q <= {ack_s_q[0], DMACK_N};
            stop_s_q <= {stop_s_q[0], STOP};
            strb_s_q <= {strb_s_q[0], HSTROBE};
            dat_s1_q <= DATA_IN;
            dat_s2_q <= dat_s1_q;
            strb_prev_q <= strb_s_q[1];
        end
    end

    assign ack_n = ack_s_q[1];
    assign stop_i = stop_s_q[1];
    assign strb_i = strb_s_q[1];

    ////////////////////////////////////////////////////////////////////////
    // crc word function
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
        logic [15:0] r;
        logic fb;
        r = c;
        for (int i = 0; i < 16; i++) begin
            fb = d[i] ^ r[15];
            r = {r[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
        end
        return r;
    endfunction : crc_step

    ////////////////////////////////////////////////////////////////////////
    // burst and termination state
    term_state_e st_q, st_d;
    logic [15:0] crc_q, crc_d;
    logic [WORDS_W-1:0] cnt_q, cnt_d;
    logic [7:0] tmr_q, tmr_d;
    logic rq_q, rq_d, rdy_n_q, rdy_n_d, oe_q, oe_d;
    logic wv_q, wv_d;
    logic [15:0] wd_q, wd_d;
    logic err_q, err_d;
    logic [15:0] host_crc_q, host_crc_d;
    logic strb_edge, ack_rise;
    logic ack_prev_q;

    assign strb_edge = strb_i != strb_prev_q;
    assign ack_rise = ack_n && !ack_prev_q;

    // acknowledge history for the release edge, idles high like the pin
    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) ack_prev_q <= 1'b1;
        else ack_prev_q <= ack_n;
    end

    always_comb begin
        st_d = st_q;
        crc_d = crc_q;
        cnt_d = cnt_q;
        tmr_d = tmr_q;
        rq_d = rq_q;
        rdy_n_d = rdy_n_q;
        oe_d = oe_q;
        wv_d = 1'b0;
        wd_d = wd_q;
        err_d = err_q;
        host_crc_d = host_crc_q;
        if (CMD_START) begin
            err_d = 1'b0;
            cnt_d = '0;
        end
        case (st_q)
            ST_IDLE: begin
                if (BURST_REQ && !CMD_START) begin
                    crc_d = `CRC_SEED;
                    rq_d = 1'b1;
                    st_d = ST_BURST;
                end
            end
            ST_BURST: begin
                if (!ack_n) begin
                    oe_d = 1'b1;
                    rdy_n_d = stop_i;
                end
                if (!ack_n && strb_edge) begin
                    crc_d = crc_step(crc_q, dat_s2_q);
                    if (cnt_q < CMD_WORDS) begin
                        wv_d = 1'b1;
                        wd_d = dat_s2_q;
                        cnt_d = cnt_q + 1'b1;
                    end
                end
                if (!ack_n && stop_i && !rdy_n_q) begin
                    rq_d = 1'b0;
                    rdy_n_d = 1'b1;
                    st_d = ST_STOPPING;
                end
            end
            ST_STOPPING: begin
                rq_d = 1'b0;
                rdy_n_d = 1'b1;
                if (ack_rise) begin
                    host_crc_d = dat_s2_q;
                    if (UDMA_MODE && (dat_s2_q != crc_q)) err_d = 1'b1;
                    tmr_d = 8'(`T_ZIORDY_CYC);
                    st_d = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                oe_d = 1'b0;
                if (tmr_q != 8'h00) tmr_d = tmr_q - 8'h01;
                else st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            st_q <= ST_IDLE;
            crc_q <= `CRC_SEED;
            cnt_q <= '0;
            tmr_q <= 8'h00;
            rq_q <= 1'b0;
            rdy_n_q <= 1'b1;
            oe_q <= 1'b0;
            wv_q <= 1'b0;
            wd_q <= 16'h0000;
            err_q <= 1'b0;
            host_crc_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            crc_q <= crc_d;
            cnt_q <= cnt_d;
            tmr_q <= tmr_d;
            rq_q <= rq_d;
            rdy_n_q <= rdy_n_d;
            oe_q <= oe_d;
            wv_q <= wv_d;
            wd_q <= wd_d;
            err_q <= err_d;
            host_crc_q <= host_crc_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // end of command reporting
    logic [7:0] er_q, er_d, asc_q, asc_d, ascq_q, ascq_d;
    logic chk_q, chk_d, done_q, done_d;
    logic [3:0] key_q, key_d;

    always_comb begin
        er_d = er_q;
        asc_d = asc_q;
        ascq_d = ascq_q;
        chk_d = chk_q;
        key_d = key_q;
        done_d = 1'b0;
        if (CMD_START) begin
            er_d = 8'h00;
            chk_d = 1'b0;
            key_d = 4'h0;
        end else if (CMD_END) begin
            done_d = 1'b1;
            if (err_q) begin
                case (CMD_KIND)
                    CMD_DMA_RW: begin
                        er_d[`ERR_ICRC_BIT] = 1'b1;
                        er_d[`ERR_ABRT_BIT] = 1'b1;
                    end
                    CMD_PKT_SENSE: begin
                        chk_d = 1'b1;
                        key_d = `SENSE_ABORTED;
                    end
                    CMD_PKT_OTHER: begin
                        chk_d = 1'b1;
                        key_d = `SENSE_HW_ERR;
                        asc_d = `ASC_COMM_CRC;
                        ascq_d = `ASCQ_COMM_CRC;
                    end
                    default: chk_d = 1'b1;
                endcase
            end
        end
    end

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            er_q <= 8'h00;
            asc_q <= 8'h00;
            ascq_q <= 8'h00;
            chk_q <= 1'b0;
            key_q <= 4'h0;
            done_q <= 1'b0;
        end else begin
            er_q <= er_d;
            asc_q <= asc_d;
            ascq_q <= ascq_d;
            chk_q <= chk_d;
            key_q <= key_d;
            done_q <= done_d;
        end
    end

    assign DMARQ = rq_q;
    assign DDMARDY_N_O = rdy_n_q;
    assign DDMARDY_N_OE = oe_q;
    assign WORD_VALID = wv_q;
    assign WORD_DATA = wd_q;
    assign CRC_ERR = err_q;
    assign ERROR_REG = er_q;
    assign CHK = chk_q;
    assign SENSE_KEY = key_q;
    assign ASC = asc_q;
    assign ASCQ = ascq_q;
    assign DONE = done_q;

    ////////////////////////////////////////////////////////////////////////
    // checks
    dmarq_drops_a: assert property (@(posedge CLK) disable iff (!NRST)
        (st_q == ST_BURST && !ack_n && stop_i && !rdy_n_q) |=> !DMARQ)
        else $error("dmarq not dropped after stop");
    dmarq_stays_a: assert property (@(posedge CLK) disable iff (!NRST)
        (st_q == ST_STOPPING) |-> !DMARQ)
        else $error("dmarq raised during termination");
    ready_held_a: assert property (@(posedge CLK) disable iff (!NRST)
        (st_q == ST_STOPPING) |-> DDMARDY_N_O)
        else $error("ready asserted during termination");
    no_fold_a: assert property (@(posedge CLK) disable iff (!NRST)
        (st_q == ST_STOPPING) |=> $stable(crc_q) || st_q == ST_RELEASE)
        else $error("crc changed on non-data strobe");
    crc_seed_a: assert property (@(posedge CLK) disable iff (!NRST)
        (st_q == ST_IDLE && BURST_REQ && !CMD_START) |=> crc_q == `CRC_SEED)
        else $error("crc not seeded");
    crc_fold_a: assert property (@(posedge CLK) disable iff (!NRST)
        (st_q == ST_BURST && !ack_n && strb_edge && !(stop_i && !rdy_n_q))
        |=> crc_q == crc_step($past(crc_q), $past(dat_s2_q)))
        else $error("crc not folded");
    err_sticky_a: assert property (@(posedge CLK) disable iff (!NRST)
        (CRC_ERR && !CMD_START) |=> CRC_ERR)
        else $error("saved crc error lost");
    icrc_report_a: assert property (@(posedge CLK) disable iff (!NRST)
        (CMD_END && !CMD_START && err_q && CMD_KIND == CMD_DMA_RW) |=> ERROR_REG[7] && ERROR_REG[2])
        else $error("icrc abort not reported");
    release_time_a: assert property (@(posedge CLK) disable iff (!NRST)
        (st_q == ST_STOPPING && ack_rise) |=> ##[0:20] !DDMARDY_N_OE)
        else $error("ready not released");
    mode_gate_a: assert property (@(posedge CLK) disable iff (!NRST)
        (!UDMA_MODE && !CRC_ERR && !CMD_START) |=> !CRC_ERR)
        else $error("crc error outside ultra mode");
    new_cmd_a: assert property (@(posedge CLK) disable iff (!NRST)
        CMD_START |=> !CRC_ERR)
        else $error("crc error not cleared by new command");
    rq_release_a: assert property (@(posedge CLK) disable iff (!NRST)
        (st_q == ST_RELEASE) |-> !DMARQ)
        else $error("dmarq raised before burst end");
    ready_driven_a: assert property (@(posedge CLK) disable iff (!NRST)
        !DDMARDY_N_O |-> DDMARDY_N_OE)
        else $error("ready asserted while not driven");
    host_crc_latch_a: assert property (@(posedge CLK) disable iff (!NRST)
        (st_q == ST_STOPPING && ack_rise) |=> host_crc_q == $past(dat_s2_q))
        else $error("host crc not latched at acknowledge release");
    err_set_a: assert property (@(posedge CLK) disable iff (!NRST)
        (st_q == ST_STOPPING && ack_rise && UDMA_MODE && dat_s2_q != crc_q) |=> CRC_ERR)
        else $error("crc mismatch not saved");
    word_pass_a: assert property (@(posedge CLK) disable iff (!NRST)
        (st_q == ST_BURST && !ack_n && strb_edge && cnt_q < CMD_WORDS)
        |=> WORD_VALID && WORD_DATA == $past(dat_s2_q))
        else $error("needed word not passed on");
    extra_drop_a: assert property (@(posedge CLK) disable iff (!NRST)
        (st_q == ST_BURST && !ack_n && strb_edge && cnt_q >= CMD_WORDS) |=> !WORD_VALID)
        else $error("extra word passed on");
    sense_report_a: assert property (@(posedge CLK) disable iff (!NRST)
        (CMD_END && !CMD_START && err_q && CMD_KIND == CMD_PKT_SENSE)
        |=> CHK && SENSE_KEY == `SENSE_ABORTED)
        else $error("sense crc error not reported as aborted");
    hw_report_a: assert property (@(posedge CLK) disable iff (!NRST)
        (CMD_END && !CMD_START && err_q && CMD_KIND == CMD_PKT_OTHER)
        |=> CHK && SENSE_KEY == `SENSE_HW_ERR && ASC == `ASC_COMM_CRC && ASCQ == `ASCQ_COMM_CRC)
        else $error("packet crc error not reported as hardware error");
    done_pulse_a: assert property (@(posedge CLK) disable iff (!NRST)
        (CMD_END && !CMD_START) |=> DONE)
        else $error("command end not reported");

endmodule : udma_out_term_crc

// ### bench/udma_host_model.sv
// host model that drives ultra dma data-out bursts
`timescale 1ns/1ps
`include "udma_crc_cfg.svh"

module udma_host_model (
    input wire logic CLK,
    input wire logic DMARQ,
    input wire logic DDMARDY_N,
    output logic DMACK_N,
    output logic STOP,
    output logic HSTROBE,
    output logic [15:0] DATA_IN,
    output logic HANG
);
    logic [15:0] crc;

    initial begin
        DMACK_N = 1'b1;
        STOP = 1'b0;
        HSTROBE = 1'b0;
        DATA_IN = 16'h0000;
        HANG = 1'b0;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : cyc

    // one word through the generator, bit 0 shifted in first
    function automatic logic [15:0] fold(input logic [15:0] c, input logic [15:0] d);
        logic fb;
        for (int i = 0; i < 16; i++) begin
            fb = d[i] ^ c[15];
            c = {c[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
        end
        return c;
    endfunction : fold

    task automatic burst(input int n, input logic [15:0] base, input bit bad);
        int i;
        crc = `CRC_SEED;
        for (i = 0; i < 40 && DMARQ !== 1'b1; i++) cyc(1);
        STOP = 1'b1;
        HSTROBE = 1'b1;
        cyc(2);
        DMACK_N = 1'b0;
        cyc(2);
        STOP = 1'b0;
        for (i = 0; i < 40 && DDMARDY_N !== 1'b0; i++) cyc(1);
        HANG = (DMARQ !== 1'b1) || (DDMARDY_N !== 1'b0);
        for (i = 0; i < n; i++) begin
            DATA_IN = base + 16'(i);
            crc = fold(crc, DATA_IN);
            cyc(1);
            HSTROBE = ~HSTROBE;
            cyc(3);
        end
        cyc(2);
        STOP = 1'b1;
        for (i = 0; i < `T_LI_CYC + 4 && (DMARQ !== 1'b0 || DDMARDY_N !== 1'b1); i++) cyc(1);
        HANG = (DMARQ !== 1'b0) || (DDMARDY_N !== 1'b1);
        HSTROBE = 1'b1;
        DATA_IN = bad ? ~crc : crc;
        cyc(4);
        DMACK_N = 1'b1;
        cyc(6);
        STOP = 1'b0;
        HSTROBE = 1'b0;
        DATA_IN = ~DATA_IN;
    endtask : burst
endmodule : udma_host_model

// ### bench/udma_out_host_term_crc_bench.sv
// self-checking bench for the data-out termination and crc block
`timescale 1ns/1ps
`include "udma_crc_cfg.svh"

module udma_out_host_term_crc_bench
    import udma_crc_pkg::*;
;
    logic CLK, NRST, DMACK_N, STOP, HSTROBE, UDMA_MODE, CMD_START, BURST_REQ, CMD_END, HANG;
    logic [15:0] DATA_IN, CMD_WORDS, WORD_DATA;
    cmd_kind_e CMD_KIND;
    logic DMARQ, DDMARDY_N_O, DDMARDY_N_OE, DDMARDY_N, WORD_VALID, CRC_ERR, CHK, DONE;
    logic [7:0] ERROR_REG, ASC, ASCQ;
    logic [3:0] SENSE_KEY;
    logic [15:0] got[$];
    logic [15:0] exp_q[$];
    int checks = 0;
    int mismatches = 0;

    // pulled up while the device does not drive it
    assign DDMARDY_N = DDMARDY_N_OE ? DDMARDY_N_O : 1'b1;

    udma_out_term_crc u_udma_out_term_crc (.CLK(CLK), .NRST(NRST), .DMACK_N(DMACK_N),
        .STOP(STOP), .HSTROBE(HSTROBE), .DATA_IN(DATA_IN), .UDMA_MODE(UDMA_MODE),
        .CMD_START(CMD_START), .CMD_KIND(CMD_KIND), .CMD_WORDS(CMD_WORDS),
        .BURST_REQ(BURST_REQ), .CMD_END(CMD_END), .DMARQ(DMARQ), .DDMARDY_N_O(DDMARDY_N_O),
        .DDMARDY_N_OE(DDMARDY_N_OE), .WORD_VALID(WORD_VALID), .WORD_DATA(WORD_DATA),
        .CRC_ERR(CRC_ERR), .ERROR_REG(ERROR_REG), .CHK(CHK), .SENSE_KEY(SENSE_KEY),
        .ASC(ASC), .ASCQ(ASCQ), .DONE(DONE));

    udma_host_model u_udma_host_model (.CLK(CLK), .DMARQ(DMARQ), .DDMARDY_N(DDMARDY_N),
        .DMACK_N(DMACK_N), .STOP(STOP), .HSTROBE(HSTROBE), .DATA_IN(DATA_IN), .HANG(HANG));

    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end

    always @(posedge CLK) if (WORD_VALID === 1'b1) got.push_back(WORD_DATA);

    always @(posedge HANG) begin
        mismatches++;
        end_sim();
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : cyc

    task automatic cmp(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : cmp

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim

    task automatic new_cmd(input cmd_kind_e k, input logic [15:0] w, input logic u);
        CMD_KIND = k;
        CMD_WORDS = w;
        UDMA_MODE = u;
        CMD_START = 1'b1;
        cyc(1);
        CMD_START = 1'b0;
        cyc(1);
        got.delete();
        exp_q.delete();
    endtask : new_cmd

    task automatic run_burst(input int n, input logic [15:0] base, input bit bad);
        BURST_REQ = 1'b1;
        cyc(1);
        BURST_REQ = 1'b0;
        u_udma_host_model.burst(n, base, bad);
        for (int i = 0; i < n; i++) if (exp_q.size() < CMD_WORDS) exp_q.push_back(base + 16'(i));
        cmp("dmarq", 16'(DMARQ), 16'h0000);
        cmp("ready_oe", 16'(DDMARDY_N_OE), 16'h0000);
        cmp("words", 16'(got.size()), 16'(exp_q.size()));
    endtask : run_burst

    task automatic end_cmd(input logic e, input logic [3:0] k, input logic [7:0] a);
        int i;
        CMD_END = 1'b1;
        cyc(1);
        CMD_END = 1'b0;
        for (i = 0; i < 20 && DONE !== 1'b1; i++) cyc(1);
        cmp("done", 16'(DONE), 16'h0001);
        cmp("crc_err", 16'(CRC_ERR), 16'(e));
        if (CMD_KIND == CMD_DMA_RW)
            cmp("error_reg", 16'(ERROR_REG), e ? 16'h0084 : 16'h0000);
        cmp("chk", 16'(CHK), 16'(e && CMD_KIND != CMD_DMA_RW));
        cmp("sense_key", 16'(SENSE_KEY), 16'(k));
        cmp("asc", 16'(ASC), 16'(a));
        cmp("ascq", 16'(ASCQ), a != 8'h00 ? 16'(`ASCQ_COMM_CRC) : 16'h0000);
        for (i = 0; i < exp_q.size() && i < got.size(); i++)
            cmp("word", got[i], exp_q[i]);
    endtask : end_cmd

    initial begin
        NRST = 1'b0;
        UDMA_MODE = 1'b0;
        CMD_START = 1'b0;
        CMD_KIND = CMD_DMA_RW;
        CMD_WORDS = 16'h0000;
        BURST_REQ = 1'b0;
        CMD_END = 1'b0;
        repeat (5) @(posedge CLK);
        #1;
        NRST = 1'b1;
        cyc(4);
        new_cmd(CMD_DMA_RW, 16'h0008, 1'b1);
        run_burst(6, 16'h1000, 1'b0);
        end_cmd(1'b0, 4'h0, 8'h00);
        new_cmd(CMD_DMA_RW, 16'h0007, 1'b1);
        run_burst(5, 16'h2200, 1'b1);
        run_burst(4, 16'h3300, 1'b0);
        end_cmd(1'b1, 4'h0, 8'h00);
        new_cmd(CMD_PKT_SENSE, 16'h0010, 1'b1);
        cmp("crc_err_clear", 16'(CRC_ERR), 16'h0000);
        run_burst(3, 16'h4400, 1'b1);
        end_cmd(1'b1, `SENSE_ABORTED, 8'h00);
        new_cmd(CMD_PKT_OTHER, 16'h0010, 1'b1);
        run_burst(4, 16'h5500, 1'b1);
        end_cmd(1'b1, `SENSE_HW_ERR, `ASC_COMM_CRC);
        new_cmd(CMD_DMA_RW, 16'h0010, 1'b0);
        run_burst(3, 16'h6600, 1'b1);
        // asc and ascq of the last packet crc error stand until another replaces them; the sense key clears at command start
        end_cmd(1'b0, 4'h0, `ASC_COMM_CRC);
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge CLK);
        mismatches++;
        end_sim();
    end
endmodule : udma_out_host_term_crc_bench
